// file: pbls_regs.v
// Self-test, loopback, status and LED source registers of the PHY
`include "pbls_consts.vh"

// Behaviour
// RULE_01 - Error tally saturates; any write clears it
// RULE_02 - Continuous mode: counter at max pulses, restarts
// RULE_03 - Software sets continuous mode before PRBS use
// RULE_04 - PRBS payload: back-to-back frames; checker stays on
// RULE_05 - Constant payload: one frame, PRBS logic off (checker is off, but the generator LFSR still steps on each byte taken)
// RULE_06 - Frame size 64 or 1518 bytes
// RULE_07 - Generator runs only while enabled
// RULE_08 - Reserved bits ignore writes, read zero
// RULE_09 - Reverse loop forwards receive data per bit
// RULE_10 - Software sets loop data bits only in mode
// RULE_11 - MII loop drives line side per bit
// RULE_12 - Loop point field is one-hot selection
// RULE_13 - Software clears coding loop before loop point
// RULE_14 - Fast ethernet coding loop placement by code
// RULE_15 - Gigabit loops before processing when low bit set
// RULE_16 - Live checker locked flag
// RULE_17 - Lock-dropped flag latches until read
// RULE_18 - Generator active flag
// RULE_19 - Master and slave legacy scramble flags
// RULE_20 - Core normal power flag
// RULE_21 - Four-bit LED source codes select events
// RULE_22 - LED source reset values 0110 and 0001
// RULE_23 - Latched status holds until its read clears
// RULE_24 - Tally counts each receive error indication
// RULE_25 - Write clear beats simultaneous increment
module pbls_regs (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Management register port
	input  wire [4:0]  mgmt_addr,
	input  wire        mgmt_wr_en,
	input  wire        mgmt_rd_en,
	input  wire [15:0] mgmt_wdata,
	output wire [15:0] mgmt_rdata,
	output wire        mgmt_rvalid,
	// Receive path observation
	input  wire        rx_error_evt,
	input  wire [7:0]  rx_byte,
	input  wire        rx_byte_valid,
	// Core state inputs
	input  wire        gig_mode,
	input  wire        legacy_master,
	input  wire        legacy_slave,
	input  wire        core_normal_power,
	// Generated byte stream toward the transmit path
	output wire [7:0]  gen_tx_data,
	output wire        gen_tx_valid,
	input  wire        gen_tx_ready,
	// Loop point selects
	output wire        loop_reverse,
	output wire        loop_external,
	output wire        loop_analog,
	output wire        loop_digital,
	output wire        rev_rx_forward,
	output wire        mii_tx_drive,
	// Coding layer loop selects
	output wire        pcs_after_mlt3,
	output wire        pcs_after_scr,
	output wire        pcs_before_scr,
	output wire        gig_before_dsp,
	// Checker counter wrap pulse
	output wire        prbs_wrap_pulse,
	// LED sources
	output wire [3:0]  aux_indicator_source,
	output wire [3:0]  indicator_two_source
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	reg  [15:0] rx_error_tally_q;
	reg  [15:0] ctrl_q;
	reg  [15:0] led_q;
	reg  [15:0] rdata_q;
	reg         rvalid_q;
	reg         checker_locked_q;
	reg         checker_lock_dropped_q;
	reg  [4:0]  match_run_q;
	reg  [14:0] hist_q;
	reg  [15:0] prbs_bytes_q;
	reg  [15:0] prbs_errs_q;
	reg         wrap_q;
	reg  [3:0]  loop_q;
	reg         rev_fwd_q;
	reg         mii_drv_q;
	reg  [3:0]  pcs_q;
	reg  [15:0] rdata_d;

	wire        wr_tally;
	wire        wr_ctrl;
	wire        wr_led;
	wire        rd_status;
	wire        cont_count;
	wire        prbs_payload;
	wire        checker_on;
	wire [7:0]  expect_byte;
	wire        byte_match;
	wire        gen_active;
	wire [7:0]  gen_byte;
	wire        gen_valid;
	wire        gen_ready;
	wire [1:0]  pcs_sel;
	wire        bytes_max;
	wire        errs_max;
	wire        count_byte;
	wire        count_err;

	// Register hits on the management port
	assign wr_tally  = mgmt_wr_en & (mgmt_addr == `PBLS_OFF_RX_ERR_COUNT);
	assign wr_ctrl   = mgmt_wr_en & (mgmt_addr == `PBLS_OFF_SELF_TEST_CTRL);
	assign wr_led    = mgmt_wr_en & (mgmt_addr == `PBLS_OFF_LED_SOURCE);
	assign rd_status = mgmt_rd_en & (mgmt_addr == `PBLS_OFF_SECOND_STATUS);

	// Control fields
	assign cont_count   = ctrl_q[`PBLS_BIT_CONT_COUNT];
	assign prbs_payload = ctrl_q[`PBLS_BIT_PRBS_PAYLOAD];
	assign checker_on   = prbs_payload; // RULE_04 RULE_05
	assign pcs_sel      = ctrl_q[1:0];

	// ---------------------------------------------------------------
	// Receive error tally
	// ---------------------------------------------------------------
	// The write clear wins, so a clear never leaves a stale count of one
	always @(posedge clk)
	begin
		if (rst)
			rx_error_tally_q <= 16'h0000;
		else if (wr_tally)
			rx_error_tally_q <= 16'h0000; // RULE_01 RULE_25
		else if (rx_error_evt && rx_error_tally_q != `PBLS_CNT_MAX)
			rx_error_tally_q <= rx_error_tally_q + 16'h0001; // RULE_24
	end

	// ---------------------------------------------------------------
	// Writable registers
	// ---------------------------------------------------------------
	// Reserved control bits are masked so they can never be set
	always @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_q <= `PBLS_RST_CTRL;
			led_q  <= `PBLS_RST_LED; // RULE_22
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= mgmt_wdata & `PBLS_CTRL_WR_MASK; // RULE_08
			if (wr_led)
				led_q <= mgmt_wdata; // RULE_21
		end
	end

	// ---------------------------------------------------------------
	// Loop point and coding layer loop decode
	// ---------------------------------------------------------------
	// Only a legal one-hot loop point code selects; anything else selects no loop point
	always @(posedge clk)
	begin
		if (rst)
		begin
			loop_q    <= 4'h0;
			rev_fwd_q <= 1'b0;
			mii_drv_q <= 1'b0;
			pcs_q     <= 4'h0;
		end
		else
		begin
			loop_q[3] <= (ctrl_q[5:2] == `PBLS_LOOP_REVERSE); // RULE_12
			loop_q[2] <= (ctrl_q[5:2] == `PBLS_LOOP_EXTERNAL);
			loop_q[1] <= (ctrl_q[5:2] == `PBLS_LOOP_ANALOG);
			loop_q[0] <= (ctrl_q[5:2] == `PBLS_LOOP_DIGITAL);
			// Suppression holds only inside the matching loop mode
			rev_fwd_q <= (ctrl_q[5:2] != `PBLS_LOOP_REVERSE) |
				ctrl_q[`PBLS_BIT_REV_FORWARD]; // RULE_09
			mii_drv_q <= (ctrl_q[5:2] != `PBLS_LOOP_DIGITAL) |
				ctrl_q[`PBLS_BIT_MII_TX_DRIVE]; // RULE_11
			pcs_q[3] <= ~gig_mode &
				(pcs_sel == `PBLS_PCS_AFTER_MLT3); // RULE_14
			pcs_q[2] <= ~gig_mode & (pcs_sel == `PBLS_PCS_AFTER_SCR);
			pcs_q[1] <= ~gig_mode & (pcs_sel == `PBLS_PCS_BEFORE_SCR);
			pcs_q[0] <= gig_mode & pcs_sel[0]; // RULE_15
		end
	end

	// ---------------------------------------------------------------
	// PRBS checker
	// ---------------------------------------------------------------
	// Self-synchronising: the history holds the newest bit of each
	// byte, so after fifteen bytes it equals the sender's state
	assign expect_byte = {hist_q[6:0], hist_q[14] ^ hist_q[13]};
	assign byte_match  = (rx_byte == expect_byte);

	always @(posedge clk)
	begin
		if (rst)
		begin
			hist_q           <= 15'h0000;
			match_run_q      <= 5'h00;
			checker_locked_q <= 1'b0;
		end
		else if (!checker_on)
		begin
			match_run_q      <= 5'h00;
			checker_locked_q <= 1'b0;
		end
		else if (rx_byte_valid)
		begin
			hist_q <= {hist_q[13:0], rx_byte[0]};
			if (!byte_match)
			begin
				match_run_q      <= 5'h00;
				checker_locked_q <= 1'b0; // RULE_16
			end
			else if (match_run_q == `PBLS_LOCK_MATCHES)
				checker_locked_q <= 1'b1;
			else
				match_run_q <= match_run_q + 5'h01;
		end
	end

	// Lock loss latches; a new loss in the read cycle still sets it
	always @(posedge clk)
	begin
		if (rst)
			checker_lock_dropped_q <= 1'b0;
		else if (checker_locked_q && !(checker_on && rx_byte_valid &&
			byte_match) && (!checker_on || rx_byte_valid))
			checker_lock_dropped_q <= 1'b1; // RULE_17 RULE_23
		else if (rd_status)
			checker_lock_dropped_q <= 1'b0; // RULE_23
	end

	// ---------------------------------------------------------------
	// PRBS byte and error counters
	// ---------------------------------------------------------------
	// Without continuous mode they just stop at the top
	assign bytes_max  = (prbs_bytes_q == `PBLS_CNT_MAX);
	assign errs_max   = (prbs_errs_q == `PBLS_CNT_MAX);
	assign count_byte = checker_on & rx_byte_valid;
	assign count_err  = count_byte & checker_locked_q & ~byte_match;

	always @(posedge clk)
	begin
		if (rst)
		begin
			prbs_bytes_q <= 16'h0000;
			prbs_errs_q  <= 16'h0000;
			wrap_q       <= 1'b0;
		end
		else
		begin
			wrap_q <= cont_count & ((count_byte & bytes_max) |
				(count_err & errs_max)); // RULE_02
			if (count_byte && bytes_max && cont_count)
				prbs_bytes_q <= 16'h0000; // RULE_02
			else if (count_byte && !bytes_max)
				prbs_bytes_q <= prbs_bytes_q + 16'h0001;
			if (count_err && errs_max && cont_count)
				prbs_errs_q <= 16'h0000;
			else if (count_err && !errs_max)
				prbs_errs_q <= prbs_errs_q + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Frame generator and its output buffer
	// ---------------------------------------------------------------
	pbls_frame_gen u_gen (
		.clk          (clk),
		.rst          (rst),
		.gen_enable   (ctrl_q[`PBLS_BIT_GEN_ENABLE]), // RULE_07
		.prbs_payload (prbs_payload), // RULE_04 RULE_05
		.short_frame  (ctrl_q[`PBLS_BIT_SHORT_FRAME]), // RULE_06
		.byte_data    (gen_byte),
		.byte_valid   (gen_valid),
		.byte_ready   (gen_ready),
		.gen_active   (gen_active)
	);

	// Two entries absorb a receiver stall without losing a byte
	pbls_word_buffer #(
		.WIDTH (8),
		.DEPTH (2)
	) u_buf (
		.clk       (clk),
		.rst       (rst),
		.in_data   (gen_byte),
		.in_valid  (gen_valid),
		.in_ready  (gen_ready),
		.out_data  (gen_tx_data),
		.out_valid (gen_tx_valid),
		.out_ready (gen_tx_ready)
	);

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Unmapped offsets read as zero
	always @*
	begin
		rdata_d = 16'h0000;
		case (mgmt_addr)
			`PBLS_OFF_RX_ERR_COUNT:
				rdata_d = rx_error_tally_q;
			`PBLS_OFF_SELF_TEST_CTRL:
				rdata_d = ctrl_q;
			`PBLS_OFF_SECOND_STATUS:
			begin
				rdata_d[`PBLS_BIT_LOCKED]        = checker_locked_q;
				rdata_d[`PBLS_BIT_LOCK_DROPPED]  = checker_lock_dropped_q;
				rdata_d[`PBLS_BIT_GEN_ACTIVE]    = gen_active; // RULE_18
				rdata_d[`PBLS_BIT_LEGACY_MASTER] = legacy_master; // RULE_19
				rdata_d[`PBLS_BIT_LEGACY_SLAVE]  = legacy_slave;
				rdata_d[`PBLS_BIT_CORE_NORMAL]   = core_normal_power; // RULE_20
			end
			`PBLS_OFF_LED_SOURCE:
				rdata_d = led_q;
			default:
				rdata_d = 16'h0000;
		endcase
	end

	// Read answer one cycle after the strobe
	always @(posedge clk)
	begin
		if (rst)
		begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= mgmt_rd_en;
			if (mgmt_rd_en)
				rdata_q <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// Output wiring, each straight from a flop
	// ---------------------------------------------------------------
	assign mgmt_rdata           = rdata_q;
	assign mgmt_rvalid          = rvalid_q;
	assign loop_reverse         = loop_q[3];
	assign loop_external        = loop_q[2];
	assign loop_analog          = loop_q[1];
	assign loop_digital         = loop_q[0];
	assign rev_rx_forward       = rev_fwd_q;
	assign mii_tx_drive         = mii_drv_q;
	assign pcs_after_mlt3       = pcs_q[3];
	assign pcs_after_scr        = pcs_q[2];
	assign pcs_before_scr       = pcs_q[1];
	assign gig_before_dsp       = pcs_q[0];
	assign prbs_wrap_pulse      = wrap_q;
	assign aux_indicator_source = led_q[15:12];
	assign indicator_two_source = led_q[11:8];

endmodule // pbls_regs

// file: pbls_consts.vh
// Constants for the PHY self-test, loopback and status register block
`ifndef PBLS_CONSTS_VH
`define PBLS_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets on the management port
// ---------------------------------------------------------------
`define PBLS_OFF_RX_ERR_COUNT   5'h15
`define PBLS_OFF_SELF_TEST_CTRL 5'h16
`define PBLS_OFF_SECOND_STATUS  5'h17
`define PBLS_OFF_LED_SOURCE     5'h18

// ---------------------------------------------------------------
// Self-test control fields
// ---------------------------------------------------------------
`define PBLS_BIT_CONT_COUNT     15
`define PBLS_BIT_PRBS_PAYLOAD   14
`define PBLS_BIT_SHORT_FRAME    13
`define PBLS_BIT_GEN_ENABLE     12
`define PBLS_BIT_REV_FORWARD    7
`define PBLS_BIT_MII_TX_DRIVE   6
`define PBLS_LOOP_HI            5
`define PBLS_LOOP_LO            2
`define PBLS_CTRL_WR_MASK       16'hF0FF
`define PBLS_RST_CTRL           16'h0000

// ---------------------------------------------------------------
// Loop point one-hot codes and coding layer loop codes
// ---------------------------------------------------------------
`define PBLS_LOOP_REVERSE       4'h8
`define PBLS_LOOP_EXTERNAL      4'h4
`define PBLS_LOOP_ANALOG        4'h2
`define PBLS_LOOP_DIGITAL       4'h1
`define PBLS_PCS_AFTER_MLT3     2'h3
`define PBLS_PCS_AFTER_SCR      2'h2
`define PBLS_PCS_BEFORE_SCR     2'h1

// ---------------------------------------------------------------
// Secondary status fields
// ---------------------------------------------------------------
`define PBLS_BIT_LOCKED         11
`define PBLS_BIT_LOCK_DROPPED   10
`define PBLS_BIT_GEN_ACTIVE     9
`define PBLS_BIT_LEGACY_MASTER  8
`define PBLS_BIT_LEGACY_SLAVE   7
`define PBLS_BIT_CORE_NORMAL    6

// ---------------------------------------------------------------
// LED source register: reset value and event codes
// ---------------------------------------------------------------
`define PBLS_RST_LED            16'h6100
`define PBLS_LED_LINK           4'h0
`define PBLS_LED_ANY_ACT        4'h1
`define PBLS_LED_TX_ACT         4'h2
`define PBLS_LED_FULL_DUPLEX    4'hA
`define PBLS_LED_LINK_BLINK     4'hB
`define PBLS_LED_RX_TX_ERR      4'hD
`define PBLS_LED_RX_ERR         4'hE

// ---------------------------------------------------------------
// Frame generator and checker counts
// ---------------------------------------------------------------
`define PBLS_LEN_SHORT          11'h040
`define PBLS_LEN_LONG           11'h5EE
`define PBLS_PRBS_SEED          15'h7FFF
`define PBLS_LOCK_MATCHES       5'h10
`define PBLS_CNT_MAX            16'hFFFF

`endif

// file: pbls_word_buffer.v
// Small shifting buffer with valid and ready on both sides
module pbls_word_buffer #(
	parameter WIDTH = 8,
	parameter DEPTH = 2
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Filling side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// Draining side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);

	reg  [WIDTH-1:0] data_q [0:DEPTH-1];
	reg  [DEPTH-1:0] vld_q;
	wire [DEPTH-1:0] sh_v;
	wire             pop;
	wire             push;

	// Push only into free room; simpler than pass-through when full
	assign pop       = vld_q[0] & out_ready;
	assign in_ready  = ~vld_q[DEPTH-1];
	assign push      = in_valid & ~vld_q[DEPTH-1];
	assign out_data  = data_q[0];
	assign out_valid = vld_q[0];

	// ---------------------------------------------------------------
	// Per entry: shift toward the head on pop, then fill first hole
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1)
		begin : g_entry
			wire [WIDTH-1:0] sh_d;
			wire             fill;
			if (i < DEPTH - 1)
			begin : g_mid
				assign sh_v[i] = pop ? vld_q[i+1] : vld_q[i];
				assign sh_d    = pop ? data_q[i+1] : data_q[i];
			end
			else
			begin : g_last
				assign sh_v[i] = pop ? 1'b0 : vld_q[i];
				assign sh_d    = data_q[i];
			end
			if (i == 0)
			begin : g_head
				assign fill = push & ~sh_v[0];
			end
			else
			begin : g_tail
				assign fill = push & ~sh_v[i] & sh_v[i-1];
			end
			always @(posedge clk)
			begin
				if (rst)
				begin
					vld_q[i]  <= 1'b0;
					data_q[i] <= {WIDTH{1'b0}};
				end
				else
				begin
					vld_q[i]  <= sh_v[i] | fill;
					data_q[i] <= fill ? in_data : sh_d;
				end
			end
		end
	endgenerate

endmodule // pbls_word_buffer

// file: pbls_frame_gen.v
// Self-test frame generator: constant single frame or PRBS frames
`include "pbls_consts.vh"
module pbls_frame_gen #(
	parameter [7:0] FILL_BYTE = 8'hA5
) (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Control
	input  wire       gen_enable,
	input  wire       prbs_payload,
	input  wire       short_frame,
	// Byte stream out
	output wire [7:0] byte_data,
	output wire       byte_valid,
	input  wire       byte_ready,
	output wire       gen_active
);

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_SEND = 2'b01;
	localparam [1:0] ST_HOLD = 2'b10;

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [10:0] left_q;
	reg  [14:0] lfsr_q;
	wire [10:0] frame_len;
	wire        take;

	assign frame_len  = short_frame ? `PBLS_LEN_SHORT : `PBLS_LEN_LONG;
	assign byte_valid = (state_q == ST_SEND);
	assign take       = byte_valid & byte_ready;
	assign byte_data  = prbs_payload ? lfsr_q[7:0] : FILL_BYTE;
	assign gen_active = byte_valid;

	// Next state; clearing the enable stops even mid-frame
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (gen_enable)
					state_d = ST_SEND;
			ST_SEND:
				if (!gen_enable)
					state_d = ST_IDLE;
				else if (take && left_q == 11'h001 && !prbs_payload)
					state_d = ST_HOLD;
			ST_HOLD:
				if (!gen_enable || prbs_payload)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// Byte count per frame and PRBS-15 advanced one bit per byte
	always @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			left_q  <= 11'h000;
			lfsr_q  <= `PBLS_PRBS_SEED;
		end
		else
		begin
			state_q <= state_d;
			if (state_q != ST_SEND || left_q == 11'h000)
				left_q <= frame_len;
			else if (take)
				left_q <= (left_q == 11'h001) ? frame_len : left_q - 11'h001;
			if (take)
				lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
		end
	end

endmodule // pbls_frame_gen

// file: pbls_regs_asserts.sv
// Port-level checks for the self-test register block
module pbls_regs_asserts (
	// Clock and reset
	input logic        clk,
	input logic        rst,
	// Management port
	input logic [4:0]  mgmt_addr,
	input logic        mgmt_wr_en,
	input logic        mgmt_rd_en,
	input logic [15:0] mgmt_rdata,
	input logic        mgmt_rvalid,
	// Observed inputs
	input logic        rx_error_evt,
	input logic        gig_mode,
	input logic        gen_tx_ready,
	// Design outputs
	input logic [7:0]  gen_tx_data,
	input logic        gen_tx_valid,
	input logic        loop_reverse,
	input logic        loop_external,
	input logic        loop_analog,
	input logic        loop_digital,
	input logic        pcs_after_mlt3,
	input logic        pcs_after_scr,
	input logic        pcs_before_scr,
	input logic        gig_before_dsp,
	input logic        prbs_wrap_pulse,
	input logic [3:0]  aux_indicator_source,
	input logic [3:0]  indicator_two_source
);
	// ----
	// Register and select checks
	// ----
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence tally_wr_s;
		mgmt_wr_en && mgmt_addr == 5'h15;
	endsequence
	sequence tally_rd_s;
		!rx_error_evt && !mgmt_wr_en ##1 mgmt_rd_en && mgmt_addr == 5'h15;
	endsequence
	// A quiet cycle between clear and read keeps increments out
	tally_clear_a: assert property (tally_wr_s ##1 tally_rd_s |=>
		mgmt_rdata == 16'h0000) else $error("tally not cleared");
	ctrl_reserved_a: assert property (mgmt_rvalid &&
		$past(mgmt_addr) == 5'h16 |-> mgmt_rdata[11:8] == 4'h0)
		else $error("control reserved bits set");
	status_reserved_a: assert property (mgmt_rvalid &&
		$past(mgmt_addr) == 5'h17 |->
		{mgmt_rdata[15:12], mgmt_rdata[5:0]} == 10'h000)
		else $error("status reserved bits set");
	loop_onehot_a: assert property ($onehot0({loop_reverse,
		loop_external, loop_analog, loop_digital}))
		else $error("two loop points at once");
	pcs_onehot_a: assert property ($onehot0({pcs_after_mlt3,
		pcs_after_scr, pcs_before_scr})) else $error("two coding loops");
	pcs_speed_a: assert property ($past(gig_mode) |->
		!(pcs_after_mlt3 || pcs_after_scr || pcs_before_scr))
		else $error("fast coding loop in gigabit");
	gig_speed_a: assert property (!$past(gig_mode) |-> !gig_before_dsp)
		else $error("gigabit loop in fast mode");
	frame_hold_a: assert property (gen_tx_valid && !gen_tx_ready |=>
		gen_tx_valid && $stable(gen_tx_data)) else $error("stalled byte lost");
	led_reset_a: assert property ($past(rst) |->
		aux_indicator_source == 4'h6 && indicator_two_source == 4'h1)
		else $error("LED source reset wrong");
	wrap_pulse_a: assert property (prbs_wrap_pulse |=> !prbs_wrap_pulse)
		else $error("wrap pulse too long");
endmodule // pbls_regs_asserts

bind pbls_regs pbls_regs_asserts u_asserts (.clk(clk), .rst(rst),
	.mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
	.mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
	.rx_error_evt(rx_error_evt), .gig_mode(gig_mode),
	.gen_tx_ready(gen_tx_ready), .gen_tx_data(gen_tx_data),
	.gen_tx_valid(gen_tx_valid), .loop_reverse(loop_reverse),
	.loop_external(loop_external), .loop_analog(loop_analog),
	.loop_digital(loop_digital), .pcs_after_mlt3(pcs_after_mlt3),
	.pcs_after_scr(pcs_after_scr), .pcs_before_scr(pcs_before_scr),
	.gig_before_dsp(gig_before_dsp), .prbs_wrap_pulse(prbs_wrap_pulse),
	.aux_indicator_source(aux_indicator_source),
	.indicator_two_source(indicator_two_source));

// file: pbls_line_model.sv
// Line-side model: stalling sink that loops taken bytes back
module pbls_line_model (
	// Clock and reset
	input  logic       clk,
	input  logic       rst,
	// Generated stream in
	input  logic [7:0] data,
	input  logic       valid,
	output logic       ready,
	input  logic       stall,
	input  logic       clr,
	// Loopback out and tallies
	output logic [7:0] lb_byte = 8'h00,
	output logic       lb_valid = 1'b0,
	output int         count = 0,
	output int         odd = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Refuse one cycle after 255 bytes and every 256 after, so the buffer sees stalls mid-frame
	assign ready = !stall && (count[7:0] != 8'hFF || !lb_valid);
	// Idle line toggles between the inverse of the last byte and the byte itself
	always @(posedge clk)
	begin
		lb_valid <= valid && ready;
		lb_byte <= (valid && ready) ? data : ~lb_byte;
		if (rst || clr)
		begin
			count <= 0;
			odd <= 0;
		end
		else if (valid && ready)
		begin
			count <= count + 1;
			odd <= odd + int'(data !== 8'hA5);
		end
	end
endmodule // pbls_line_model

// file: tb_pbls_regs.sv
// Self-checking bench for the self-test register block
module tb_pbls_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic [15:0] wdata = 16'h0000, rdata;
	logic        evt = 1'b0, gig = 1'b0, lm = 1'b1, ls = 1'b0, pw = 1'b1;
	logic [7:0]  gd, lb;
	logic        gv, gr, lbv, rvalid, fwd, drv, gdsp, wp;
	logic        stall = 1'b1, clr = 1'b0;
	logic [3:0]  lp, aux, two;
	logic [2:0]  pcs;
	int          errors = 0, comparisons = 0, cyc = 0, n, cnt, odd, wraps = 0;
	logic [15:0] lt [6] = '{16'h00A0, 16'h0020, 16'h0010, 16'h0008,
		16'h0044, 16'h0004};
	logic [3:0]  led [7] = '{4'h0, 4'h1, 4'h2, 4'hA, 4'hB, 4'hD, 4'hE};

	// ----
	// Design, line model and clock
	// ----
	pbls_regs DUT (.clk(clk), .rst(rst), .mgmt_addr(addr),
		.mgmt_wr_en(wr_en), .mgmt_rd_en(rd_en), .mgmt_wdata(wdata),
		.mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .rx_error_evt(evt),
		.rx_byte(lb), .rx_byte_valid(lbv), .gig_mode(gig),
		.legacy_master(lm), .legacy_slave(ls), .core_normal_power(pw),
		.gen_tx_data(gd), .gen_tx_valid(gv), .gen_tx_ready(gr),
		.loop_reverse(lp[3]), .loop_external(lp[2]), .loop_analog(lp[1]),
		.loop_digital(lp[0]), .rev_rx_forward(fwd), .mii_tx_drive(drv),
		.pcs_after_mlt3(pcs[2]), .pcs_after_scr(pcs[1]),
		.pcs_before_scr(pcs[0]), .gig_before_dsp(gdsp),
		.prbs_wrap_pulse(wp), .aux_indicator_source(aux),
		.indicator_two_source(two));
	pbls_line_model u_line (.clk(clk), .rst(rst), .data(gd), .valid(gv),
		.ready(gr), .stall(stall), .clr(clr), .lb_byte(lb),
		.lb_valid(lbv), .count(cnt), .odd(odd));
	always #10 clk = ~clk;
	// Hang guard well past the expected run length
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		wraps <= wraps + int'(wp);
		if (cyc == 90000)
		begin
			errors++;
			summarize;
		end
	end

	// ----
	// Access and compare tasks
	// ----
	task chk(input logic [15:0] g, input logic [15:0] e);
	begin
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	task reg_wr(input logic [4:0] a, input logic [15:0] v, input logic e);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		evt <= e;
		@(posedge clk);
		wr_en <= 1'b0;
		evt <= 1'b0;
	end
	endtask
	// The answer stands one cycle, so it is looked at just after its edge
	task reg_rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
	begin
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk({15'h0000, rvalid}, 16'h0001);
		chk(rdata & m, e);
	end
	endtask
	// One generator run; starts stalled to fill the buffer
	task gen_frame(input logic [15:0] v, input int len);
	begin
		reg_wr(5'h16, 16'h8000, 1'b0);
		@(posedge clk);
		{stall, clr} <= 2'b11;
		@(posedge clk);
		clr <= 1'b0;
		reg_wr(5'h16, v, 1'b0);
		repeat (8) @(posedge clk);
		reg_rd(5'h17, 16'hFFFF, 16'h0280);
		@(posedge clk);
		stall <= 1'b0;
		for (n = 0; n < 4000 && cnt < len; n++) @(posedge clk);
		repeat (40) @(posedge clk);
		chk(cnt[15:0], len[15:0]);
		chk(odd[15:0], 16'h0000);
		reg_rd(5'h17, 16'hFFFF, 16'h0080);
	end
	endtask
	task summarize;
	begin
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask

	// ----
	// Test sequence
	// ----
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		reg_rd(5'h16, 16'hFFFF, 16'h0000);
		reg_rd(5'h18, 16'hFF00, 16'h6100);
		reg_rd(5'h17, 16'hFFFF, 16'h0140);
		reg_wr(5'h17, 16'hFFFF, 1'b0);
		reg_wr(5'h16, 16'h0F00, 1'b0);
		reg_wr(5'h00, 16'hFFFF, 1'b0);
		reg_rd(5'h17, 16'hFFFF, 16'h0140);
		reg_rd(5'h16, 16'hFFFF, 16'h0000);
		reg_rd(5'h00, 16'hFFFF, 16'h0000);
		@(posedge clk);
		{lm, ls, pw} <= 3'b010;
		reg_rd(5'h17, 16'hFFFF, 16'h0080);
		// Error tally: count, racing clear, saturation
		@(posedge clk);
		evt <= 1'b1;
		repeat (3) @(posedge clk);
		evt <= 1'b0;
		reg_rd(5'h15, 16'hFFFF, 16'h0003);
		reg_wr(5'h15, 16'h5A5A, 1'b1);
		reg_rd(5'h15, 16'hFFFF, 16'h0000);
		reg_wr(5'h16, 16'hD000, 1'b0);
		@(posedge clk);
		{evt, stall} <= 2'b10;
		repeat (66000) @(posedge clk);
		evt <= 1'b0;
		reg_rd(5'h15, 16'hFFFF, 16'hFFFF);
		reg_wr(5'h15, 16'h0000, 1'b0);
		reg_rd(5'h15, 16'hFFFF, 16'h0000);
		// Loop points with their data control bits
		foreach (lt[i])
		begin
			reg_wr(5'h16, 16'h0000, 1'b0);
			reg_wr(5'h16, lt[i], 1'b0);
			repeat (2) @(posedge clk);
			#1;
			chk({12'h000, lp}, {12'h000, lt[i][5:2]});
			chk({14'h0000, fwd, drv}, {14'h0000, lt[i][5] ? lt[i][7] : 1'b1,
				lt[i][2] ? lt[i][6] : 1'b1});
		end
		// Coding layer loops in both speeds; speed moves only while off
		for (n = 1; n < 8; n++)
		begin
			reg_wr(5'h16, 16'h0000, 1'b0);
			@(posedge clk);
			gig <= n[2];
			reg_wr(5'h16, {14'h0000, n[1:0]}, 1'b0);
			repeat (2) @(posedge clk);
			#1;
			chk({12'h000, pcs, gdsp}, n[2] ? {15'h0000, n[0]} :
				{12'h000, n[1:0] == 2'd3, n[1:0] == 2'd2,
				n[1:0] == 2'd1, 1'b0});
		end
		reg_wr(5'h16, 16'h0000, 1'b0);
		@(posedge clk);
		gig <= 1'b0;
		// LED event codes
		foreach (led[i])
		begin
			reg_wr(5'h18, {led[i], ~led[i], 8'h00}, 1'b0);
			reg_rd(5'h18, 16'hFF00, {led[i], ~led[i], 8'h00});
			chk({8'h00, aux, two}, {8'h00, led[i], ~led[i]});
		end
		reg_rd(5'h17, 16'hFFFF, 16'h0480);
		// Generator: constant frames, then PRBS with checker lock
		gen_frame(16'hB000, 64);
		gen_frame(16'h9000, 1518);
		reg_wr(5'h16, 16'hD000, 1'b0);
		repeat (300) @(posedge clk);
		reg_rd(5'h17, 16'hFFFF, 16'h0A80);
		chk({15'h0000, cnt > 1600}, 16'h0001);
		reg_wr(5'h16, 16'hC000, 1'b0);
		repeat (20) @(posedge clk);
		n = cnt;
		repeat (30) @(posedge clk);
		chk(cnt[15:0], n[15:0]);
		reg_rd(5'h17, 16'hFFFF, 16'h0880);
		reg_wr(5'h16, 16'h8000, 1'b0);
		reg_rd(5'h17, 16'hFFFF, 16'h0480);
		reg_rd(5'h17, 16'hFFFF, 16'h0080);
		chk(wraps[15:0], 16'h0001);
		summarize;
	end
endmodule // tb_pbls_regs
